// ### logic/sci_defs.vh
`ifndef SCI_DEFS_VH
`define SCI_DEFS_VH

// ==========================================================
// Register map (index; byte address is four times the index)
// ==========================================================
`define SCI_IX_DATA      2'd0
`define SCI_IX_STAT      2'd1
`define SCI_ADDR_W       4

// ==========================================================
// Status register fields
// ==========================================================
`define SCI_ST_CMD_EMPTY 7
`define SCI_ST_RESP_RDY  6
`define SCI_ST_ALARM     5

// ==========================================================
// Opcode bases (channel in low three bits; REP, OPEN and ALL are whole opcodes)
// ==========================================================
`define SCI_OP_TYPE      8'h10
`define SCI_OP_LIM       8'h20
`define SCI_OP_REP       8'h30
`define SCI_OP_OPEN      8'h50
`define SCI_OP_ALL       8'h58
`define SCI_OP_TARE      8'h70
`define SCI_OP_CALF      8'h80
`define SCI_OP_CALL      8'h90
`define SCI_OP_NULL      8'hB0
`define SCI_OP_SPAN      8'hD0

// ==========================================================
// Argument byte counts per command
// ==========================================================
`define SCI_LEN_TYPE     3'd1
`define SCI_LEN_LIM      3'd4
`define SCI_LEN_OPEN     3'd1
`define SCI_LEN_CAL      3'd6
`define SCI_LEN_SPAN     3'd2

// ==========================================================
// Values and sizes
// ==========================================================
`define SCI_LIM_LOW_RST  16'h8000
`define SCI_LIM_HIGH_RST 16'h7FFF
`define SCI_OPEN_LOW     16'h8000
`define SCI_OPEN_HIGH    16'h7FFF
`define SCI_NCH          8
`define SCI_CAL_BYTES    6
`define SCI_RESP_MAX     16

`endif

// ### logic/sci_top.v
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sci_defs.vh"

module sci_top #(
    parameter [7:0]  OFF_TYPE = 8'h00,   // Type code meaning disabled
    parameter [15:0] NO_DATA  = 16'h8000 // Reading shown by a single-channel read while stale
) (
    input  wire                    clk_in,
    input  wire                    rst_in,
    input  wire [`SCI_ADDR_W-1:0]  avs_address_in,
    input  wire                    avs_read_in,
    input  wire                    avs_write_in,
    input  wire [31:0]             avs_writedata_in,
    input  wire [3:0]              avs_byteenable_in,
    output reg  [31:0]             avs_readdata_out,
    output reg                     avs_waitrequest_out,
    input  wire                    sample_strobe_in,
    input  wire [15:0]             sample_value_in,
    input  wire                    sample_open_in,
    output reg  [2:0]              scan_chan_out,
    output reg  [7:0]              scan_type_out,
    output reg                     alarm_out
);

    // ==========================================================
    // Command kinds
    // ==========================================================
    localparam [3:0] K_NONE = 4'd0;
    localparam [3:0] K_ONE  = 4'd1;
    localparam [3:0] K_TYPE = 4'd2;
    localparam [3:0] K_LIM  = 4'd3;
    localparam [3:0] K_REP  = 4'd4;
    localparam [3:0] K_OPEN = 4'd5;
    localparam [3:0] K_ALL  = 4'd6;
    localparam [3:0] K_TARE = 4'd7;
    localparam [3:0] K_CALF = 4'd8;
    localparam [3:0] K_CALL = 4'd9;
    localparam [3:0] K_NULL = 4'd10;
    localparam [3:0] K_SPAN = 4'd11;

    // Opcode to kind; channel bits must be 0..7 by construction
    function [3:0] op_kind;
        input [7:0] op;
        begin
            if (op[7:3] == 5'd0)
                op_kind = K_ONE;
            else if ({op[7:3], 3'b000} == `SCI_OP_TYPE)
                op_kind = K_TYPE;
            else if ({op[7:3], 3'b000} == `SCI_OP_LIM)
                op_kind = K_LIM;
            else if (op == `SCI_OP_REP)
                op_kind = K_REP;
            else if (op == `SCI_OP_OPEN)
                op_kind = K_OPEN;
            else if (op == `SCI_OP_ALL)
                op_kind = K_ALL;
            else if ({op[7:3], 3'b000} == `SCI_OP_TARE)
                op_kind = K_TARE;
            else if ({op[7:3], 3'b000} == `SCI_OP_CALF)
                op_kind = K_CALF;
            else if ({op[7:3], 3'b000} == `SCI_OP_CALL)
                op_kind = K_CALL;
            else if ({op[7:3], 3'b000} == `SCI_OP_NULL)
                op_kind = K_NULL;
            else if ({op[7:3], 3'b000} == `SCI_OP_SPAN)
                op_kind = K_SPAN;
            else
                op_kind = K_NONE;
        end
    endfunction

    // Argument bytes that follow the opcode
    function [2:0] cmd_len;
        input [7:0] op;
        begin
            case (op_kind(op))
                K_TYPE:  cmd_len = `SCI_LEN_TYPE;
                K_LIM:   cmd_len = `SCI_LEN_LIM;
                K_OPEN:  cmd_len = `SCI_LEN_OPEN;
                K_CALL:  cmd_len = `SCI_LEN_CAL;
                K_SPAN:  cmd_len = `SCI_LEN_SPAN;
                default: cmd_len = 3'd0;
            endcase
        end
    endfunction

    // Next enabled channel after cur; cur itself if none other
    function [2:0] next_chan;
        input [2:0] cur;
        input [7:0] en;
        integer     k;
        reg   [2:0] c;
        begin
            next_chan = cur;
            for (k = 7; k >= 1; k = k - 1)
            begin
                c = cur + k[2:0];
                if (en[c])
                    next_chan = c;
            end
        end
    endfunction

    // Byte slot of a channel's calibration set
    function [5:0] cal_ix;
        input [2:0] ch;
        input [2:0] i;
        begin
            cal_ix = {ch, 2'b00} + {2'b00, ch, 1'b0} + {3'b000, i};
        end
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    reg  [7:0]         chan_type [0:7];    // Declared sensor types
    reg  [15:0]        samp      [0:7];    // Latest readings
    reg  signed [15:0] hi_lim    [0:7];    // High alarm limits
    reg  signed [15:0] lo_lim    [0:7];    // Low alarm limits
    reg  [7:0]         cal_mem   [0:47];   // Gauge calibration bytes
    reg  [7:0]         resp      [0:15];   // Response string
    reg  [7:0]         args      [0:5];    // Collected argument bytes
    reg  [7:0]         op_reg;             // Opcode being collected
    reg  [2:0]         need_reg;           // Argument count expected
    reg  [2:0]         idx_reg;            // Bytes received so far
    reg                go_reg;             // Execute pulse
    reg  [4:0]         rlen_reg;           // Response length
    reg  [4:0]         rptr_reg;           // Next response byte
    reg  [7:0]         fail_dir_reg;       // Open-sensor direction
    reg  [7:0]         hi_flag_reg;        // High violations
    reg  [7:0]         lo_flag_reg;        // Low violations
    reg  [7:0]         stale1_reg;         // Declared, partial scan
    reg  [7:0]         stale2_reg;         // Awaiting full scan
    integer            i;

    // ==========================================================
    // Scanner and alarm compare
    // ==========================================================
    wire [7:0] en_mask;                    // Channels not disabled
    genvar g;
    generate
        for (g = 0; g < `SCI_NCH; g = g + 1)
        begin : g_en
            assign en_mask[g] = (chan_type[g] != OFF_TYPE);
        end
    endgenerate

    wire [2:0] nxt_ch = next_chan(scan_chan_out, en_mask);
    wire       wrap   = (nxt_ch <= scan_chan_out);
    // Open sensor forced to the rail chosen by its direction bit
    wire [15:0] sv = !sample_open_in ? sample_value_in :
                     fail_dir_reg[scan_chan_out] ? `SCI_OPEN_HIGH :
                     `SCI_OPEN_LOW;
    wire hit_hi = sample_strobe_in &&
                  ($signed(sv) > hi_lim[scan_chan_out]);
    wire hit_lo = sample_strobe_in &&
                  ($signed(sv) < lo_lim[scan_chan_out]);

    // ==========================================================
    // Bus decode
    // ==========================================================
    wire req     = avs_read_in | avs_write_in;
    wire ack     = req & ~avs_waitrequest_out;   // Access completes
    wire word_ok = (avs_address_in[1:0] == 2'b00);
    wire [1:0] ix = avs_address_in[3:2];
    wire response_ready_flag     = (rptr_reg != rlen_reg);
    wire command_empty_flag    = ~response_ready_flag & ~go_reg;

    // Read mux; unmapped words read as zero
    reg [31:0] rd_word;
    always @*
    begin
        rd_word = 32'h0000_0000;
        if (word_ok && ix == `SCI_IX_DATA)
        begin
            if (response_ready_flag)
                rd_word[7:0] = resp[rptr_reg[3:0]];
        end
        else if (word_ok && ix == `SCI_IX_STAT)
        begin
            rd_word[`SCI_ST_CMD_EMPTY] = command_empty_flag;
            rd_word[`SCI_ST_RESP_RDY]  = response_ready_flag;
            rd_word[`SCI_ST_ALARM]     = alarm_out;
        end
    end

    wire cmd_wr = ack & avs_write_in & avs_byteenable_in[0] &
                  word_ok & (ix == `SCI_IX_DATA);
    wire [7:0] wb = avs_writedata_in[7:0];
    wire [2:0] ch = op_reg[2:0];           // Channel of the command

    // ==========================================================
    // Main process
    // ==========================================================
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            avs_readdata_out    <= 32'h0000_0000;
            avs_waitrequest_out <= 1'b1;
            scan_chan_out       <= 3'd0;
            scan_type_out       <= 8'h00;
            alarm_out           <= 1'b0;
            op_reg              <= 8'h00;
            need_reg            <= 3'd0;
            idx_reg             <= 3'd0;
            go_reg              <= 1'b0;
            rlen_reg            <= 5'd0;
            rptr_reg            <= 5'd0;
            fail_dir_reg        <= 8'h00;
            hi_flag_reg         <= 8'h00;
            lo_flag_reg         <= 8'h00;
            stale1_reg          <= 8'h00;
            stale2_reg          <= 8'h00;
            for (i = 0; i < 8; i = i + 1)
            begin
                chan_type[i] <= 8'h00;
                samp[i]      <= 16'h0000;
                hi_lim[i]    <= `SCI_LIM_HIGH_RST;
                lo_lim[i]    <= `SCI_LIM_LOW_RST;
            end
            for (i = 0; i < 48; i = i + 1)
                cal_mem[i] <= 8'h00;
            for (i = 0; i < 16; i = i + 1)
                resp[i] <= 8'h00;
            for (i = 0; i < 6; i = i + 1)
                args[i] <= 8'h00;
        end
        else
        begin
            go_reg        <= 1'b0;
            scan_type_out <= chan_type[scan_chan_out];
            // One wait-free cycle per access, then back to waiting
            avs_waitrequest_out <= ~(req & avs_waitrequest_out);
            if (req & avs_waitrequest_out)
                avs_readdata_out <= rd_word;
            // Command byte collection; ignored while not empty
            if (cmd_wr && command_empty_flag)
            begin
                if (idx_reg == 3'd0)
                begin
                    op_reg   <= wb;
                    need_reg <= cmd_len(wb);
                    if (cmd_len(wb) == 3'd0)
                        go_reg <= 1'b1;
                    else
                        idx_reg <= 3'd1;
                end
                else
                begin
                    args[idx_reg - 3'd1] <= wb;
                    if (idx_reg == need_reg)
                    begin
                        go_reg  <= 1'b1;
                        idx_reg <= 3'd0;
                    end
                    else
                        idx_reg <= idx_reg + 3'd1;
                end
            end
            // Response bytes leave in order, one per read
            if (ack && avs_read_in && word_ok &&
                ix == `SCI_IX_DATA && response_ready_flag)
                rptr_reg <= rptr_reg + 5'd1;
            // Sample capture, alarms and scan advance
            if (sample_strobe_in)
            begin
                samp[scan_chan_out] <= sv;
                scan_chan_out       <= nxt_ch;
                if (hit_hi)
                    hi_lim[scan_chan_out] <= `SCI_LIM_HIGH_RST;
                if (hit_lo)
                    lo_lim[scan_chan_out] <= `SCI_LIM_LOW_RST;
                if (wrap)
                begin
                    // Second wrap after a declare ends a full scan
                    stale2_reg <= stale1_reg;
                    stale1_reg <= 8'h00;
                end
            end
            // Flags: a new hit wins over the report's clear
            if (go_reg && op_kind(op_reg) == K_REP)
            begin
                hi_flag_reg <= hit_hi ? (8'h01 << scan_chan_out) : 8'h00;
                lo_flag_reg <= hit_lo ? (8'h01 << scan_chan_out) : 8'h00;
                alarm_out   <= hit_hi | hit_lo;
            end
            else
            begin
                if (hit_hi)
                    hi_flag_reg[scan_chan_out] <= 1'b1;
                if (hit_lo)
                    lo_flag_reg[scan_chan_out] <= 1'b1;
                if (hit_hi | hit_lo)
                    alarm_out <= 1'b1;
            end
            // Execute a complete command
            if (go_reg)
            begin
                rptr_reg <= 5'd0;
                rlen_reg <= 5'd0;
                case (op_kind(op_reg))
                    K_ONE:
                    begin
                        resp[0] <= stale1_reg[ch] | stale2_reg[ch] ?
                                   NO_DATA[15:8] : samp[ch][15:8];
                        resp[1] <= stale1_reg[ch] | stale2_reg[ch] ?
                                   NO_DATA[7:0] : samp[ch][7:0];
                        rlen_reg <= 5'd2;
                    end
                    K_ALL:
                    begin
                        for (i = 0; i < 8; i = i + 1)
                        begin
                            resp[2*i]   <= samp[i][15:8];
                            resp[2*i+1] <= samp[i][7:0];
                        end
                        rlen_reg <= 5'd`SCI_RESP_MAX;
                    end
                    K_TYPE:
                    begin
                        chan_type[ch]  <= args[0];
                        stale1_reg[ch] <= 1'b1;
                        stale2_reg[ch] <= 1'b0;
                    end
                    K_OPEN:  fail_dir_reg <= args[0];
                    K_LIM:
                    begin
                        hi_lim[ch] <= {args[0], args[1]};
                        lo_lim[ch] <= {args[2], args[3]};
                    end
                    K_REP:
                    begin
                        resp[0]  <= hi_flag_reg;
                        resp[1]  <= lo_flag_reg;
                        rlen_reg <= 5'd2;
                    end
                    K_NULL:
                    begin
                        cal_mem[cal_ix(ch, 3'd0)] <= samp[ch][15:8];
                        cal_mem[cal_ix(ch, 3'd1)] <= samp[ch][7:0];
                    end
                    K_SPAN:
                    begin
                        cal_mem[cal_ix(ch, 3'd2)] <= args[0];
                        cal_mem[cal_ix(ch, 3'd3)] <= args[1];
                    end
                    K_TARE:
                    begin
                        cal_mem[cal_ix(ch, 3'd4)] <= samp[ch][15:8];
                        cal_mem[cal_ix(ch, 3'd5)] <= samp[ch][7:0];
                    end
                    K_CALF:
                    begin
                        for (i = 0; i < 6; i = i + 1)
                            resp[i] <= cal_mem[cal_ix(ch, i[2:0])];
                        rlen_reg <= 5'd`SCI_CAL_BYTES;
                    end
                    K_CALL:
                    begin
                        for (i = 0; i < 6; i = i + 1)
                            cal_mem[cal_ix(ch, i[2:0])] <= args[i];
                    end
                    default: rlen_reg <= 5'd0; // Unknown opcode dropped
                endcase
            end
        end
    end

endmodule // sci_top

`default_nettype wire

// ### verification/sci_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker for the command interpreter
// ==========================================================
module sci_chk (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [3:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        sample_strobe_in,
    input wire logic [2:0]  scan_chan_out,
    input wire logic        alarm_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Read answered this cycle
    wire rd_ack = avs_read_in && !avs_waitrequest_out;
    // Status word answered this cycle
    wire st_ack = rd_ack && (avs_address_in == 4'h4);
    // Request seen while held off
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    // One low cycle, then held off again
    sequence s_ack;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    a_wait_one_cycle: assert property (s_req |=> s_ack)
        else $error("bus answer not exactly one cycle");
    a_wait_low_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    a_idle_held_off: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
        else $error("waitrequest low without request");
    a_read_one_byte: assert property (rd_ack |-> avs_readdata_out[31:8] == 24'h00_0000)
        else $error("read data above byte lane");
    a_status_spare_zero: assert property (st_ack |-> avs_readdata_out[4:0] == 5'h00)
        else $error("status spare bits set");
    a_alarm_in_status: assert property (st_ack |-> avs_readdata_out[5] == $past(alarm_out))
        else $error("status alarm bit differs from alarm output");
    a_alarm_from_sample: assert property ($rose(alarm_out) |-> $past(sample_strobe_in))
        else $error("alarm raised without a sample");
    a_scan_holds_still: assert property (!sample_strobe_in |=> $stable(scan_chan_out))
        else $error("scan channel moved without a sample");
endmodule // sci_chk
bind sci_top sci_chk u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .sample_strobe_in(sample_strobe_in), .scan_chan_out(scan_chan_out),
    .alarm_out(alarm_out)
);
`default_nettype wire

// ### verification/sci_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Converter model: one sample every four cycles
// ==========================================================
module sci_sensor_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [2:0]  scan_chan_in,
    output var  logic        strobe_out,
    output var  logic [15:0] value_out,
    output var  logic        open_out
);
    logic [15:0] value_tbl [8]; // Reading per channel, set by bench
    logic [7:0]  open_tbl;      // Open sensor per channel
    logic [1:0]  gap_cnt;       // Spacing between samples
    // Default readings
    initial
    begin
        for (int i = 0; i < 8; i++)
            value_tbl[i] = 16'h1111 * i[15:0] + 16'h0102;
        open_tbl = 8'h00;
    end
    // Sample issue; lines toggle between samples so stale data never matches
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gap_cnt    <= 2'h0;
            strobe_out <= 1'b0;
            value_out  <= 16'h0000;
            open_out   <= 1'b0;
        end
        else
        begin
            gap_cnt    <= gap_cnt + 2'h1;
            strobe_out <= (gap_cnt == 2'h3);
            value_out  <= (gap_cnt == 2'h3) ? value_tbl[scan_chan_in] : ~value_out;
            open_out   <= (gap_cnt == 2'h3) ? open_tbl[scan_chan_in] : ~open_out;
        end
    end
endmodule // sci_sensor_model
`default_nettype wire

// ### verification/test_sensor_command_interpreter.sv
`timescale 1ns/1ps
`default_nettype none
`include "sci_defs.vh"
// ==========================================================
// Self-checking bench
// ==========================================================
module test_sensor_command_interpreter;
    logic        clk_in, rst_in, rd, wr;   // Clock, reset, bus strobes
    logic [3:0]  addr;                     // Bus byte address
    logic [31:0] wdata, rdata;             // Bus data
    logic        waitreq, strobe, open;    // Handshake and sample link
    logic [15:0] value;                    // Sample value
    logic [2:0]  scan_chan;                // Channel under conversion
    logic [7:0]  scan_type;                // Type of that channel
    logic        alarm;                    // Alarm output
    int          num_errors, tests_run, cycle_cnt;
    sci_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .sample_strobe_in(strobe), .sample_value_in(value), .sample_open_in(open),
        .scan_chan_out(scan_chan), .scan_type_out(scan_type), .alarm_out(alarm));
    sci_sensor_model model_u (.clk_in(clk_in), .rst_in(rst_in), .scan_chan_in(scan_chan),
        .strobe_out(strobe), .value_out(value), .open_out(open));
    // ======================================================
    // Bus and compare helpers
    // ======================================================
    function automatic logic [15:0] exp_val(input int i);
        return 16'h1111 * i[15:0] + 16'h0102;
    endfunction
    // One access, held until waitrequest is sampled low
    task automatic bus_op(input logic w, input logic [3:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk_in);
        addr  <= a;
        wdata <= {24'h00_0000, d};
        wr    <= w;
        rd    <= !w;
        do @(posedge clk_in); while (waitreq !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic [7:0] st;
        do bus_op(1'b0, 4'h4, 8'h00, st); while (st[7] !== 1'b1);
        bus_op(1'b1, 4'h0, b, st);
    endtask
    task automatic get_byte(output logic [7:0] b);
        logic [7:0] st;
        do bus_op(1'b0, 4'h4, 8'h00, st); while (st[6] !== 1'b1);
        bus_op(1'b0, 4'h0, 8'h00, b);
    endtask
    task automatic get_word(output logic [15:0] w);
        get_byte(w[15:8]);
        get_byte(w[7:0]);
    endtask
    task automatic check_status(input logic [7:0] exp);
        logic [7:0] st;
        bus_op(1'b0, 4'h4, 8'h00, st);
        check({8'h00, st}, {8'h00, exp});
    endtask
    // Waits until channel 7 has been sampled n times
    task automatic wait_wraps(input int n);
        for (int k = 0; k < n; )
        begin
            @(posedge clk_in);
            if (strobe === 1'b1 && scan_chan === 3'h7) k++;
        end
    endtask
    // ======================================================
    // Scenarios
    // ======================================================
    task automatic t_reset;
        logic [7:0] b;
        check_status(8'h80);
        bus_op(1'b0, 4'h0, 8'h00, b);
        check({8'h00, b}, 16'h0000);
        bus_op(1'b0, 4'h1, 8'h00, b);
        check({8'h00, b}, 16'h0000);
        $display("done: reset");
    endtask
    task automatic t_types;
        logic [15:0] w;
        for (int i = 0; i < 8; i++)
        begin
            send_byte(`SCI_OP_TYPE + i[7:0]);
            send_byte(8'h01);
        end
        send_byte(8'h07);
        get_word(w);
        check(w, 16'h8000);
        wait_wraps(3);
        check({8'h00, scan_type}, 16'h0001);
        for (int i = 0; i < 8; i++)
        begin
            send_byte(i[7:0]);
            get_word(w);
            check(w, exp_val(i));
        end
        check_status(8'h80);
        send_byte(`SCI_OP_ALL);
        for (int i = 0; i < 8; i++)
        begin
            get_word(w);
            check(w, exp_val(i));
        end
        $display("done: types and reads");
    endtask
    task automatic t_refused;
        logic [15:0] w;
        logic [7:0]  b;
        send_byte(8'h04);
        bus_op(1'b1, 4'h0, `SCI_OP_ALL, b); // Dropped: response pending
        get_word(w);
        check(w, exp_val(4));
        check_status(8'h80);
        $display("done: refused write");
    endtask
    task automatic t_open;
        logic [15:0] w;
        send_byte(`SCI_OP_OPEN);
        send_byte(8'h02);
        model_u.open_tbl = 8'h06;
        wait_wraps(2);
        send_byte(8'h01);
        get_word(w);
        check(w, 16'h7FFF);
        send_byte(8'h02);
        get_word(w);
        check(w, 16'h8000);
        model_u.open_tbl = 8'h00;
        wait_wraps(2);
        $display("done: open sensor");
    endtask
    task automatic t_limits;
        logic [7:0] b;
        send_byte(`SCI_OP_LIM + 8'h04);
        send_byte(8'h45);
        send_byte(8'h45);
        wait_wraps(2);
        check_status(8'h80); // Not yet executed
        send_byte(8'h80);
        send_byte(8'h00);
        wait_wraps(2);
        check_status(8'hA0);
        send_byte(`SCI_OP_REP);
        get_byte(b);
        check({8'h00, b}, 16'h0010);
        get_byte(b);
        check({8'h00, b}, 16'h0000);
        check_status(8'h80);
        wait_wraps(2);
        check_status(8'h80); // Violated limit restored
        $display("done: alarm limits");
    endtask
    task automatic t_gauge;
        logic [7:0] cal [6];
        logic [7:0] b;
        cal = '{8'h01, 8'h02, 8'h0B, 8'hCD, 8'h03, 8'h33};
        send_byte(`SCI_OP_NULL);
        send_byte(`SCI_OP_SPAN);
        send_byte(8'h0B);
        send_byte(8'hCD);
        model_u.value_tbl[0] = 16'h0333;
        wait_wraps(2);
        send_byte(`SCI_OP_TARE);
        send_byte(`SCI_OP_CALF);
        for (int i = 0; i < 6; i++)
        begin
            get_byte(b);
            check({8'h00, b}, {8'h00, cal[i]});
        end
        send_byte(`SCI_OP_CALL + 8'h01);
        for (int i = 0; i < 6; i++) send_byte(cal[i]);
        repeat (100) @(posedge clk_in); // Short settle; no real delay modelled
        send_byte(`SCI_OP_CALF + 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            get_byte(b);
            check({8'h00, b}, {8'h00, cal[i]});
        end
        $display("done: gauge");
    endtask
    task automatic t_disable;
        int hits;
        hits = 0;
        send_byte(`SCI_OP_TYPE + 8'h05);
        send_byte(8'h00);
        wait_wraps(1);
        repeat (96) @(posedge clk_in) if (strobe === 1'b1 && scan_chan === 3'h5) hits++;
        check(hits[15:0], 16'h0000);
        $display("done: disabled channel");
    endtask
    // ======================================================
    // Verdict, timeout and main sequence
    // ======================================================
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // Hang guard, well above the expected run length
    always @(posedge clk_in)
    begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 40000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    initial
    begin
        {rst_in, rd, wr, addr, wdata} = {1'b1, 38'h0};
        {num_errors, tests_run, cycle_cnt} = '0;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_types();
        t_refused();
        t_open();
        t_limits();
        t_gauge();
        t_disable();
        print_verdict();
    end
endmodule // test_sensor_command_interpreter
`default_nettype wire
